// ==== rtl/bsc_pkg.sv ====
// package: constants and types for the boot select and configuration loader
//
// Function
// - non-software reset: configured boot bit 1 boots application flash, 0 loader flash
// - software write of boot select: 0 next boot application, 1 loader
// - boot select read returns block booted at previous reset
// - non-software reset loads boot select with inverse of configured boot bit
// - boot block chosen from boot select control only at reset release
// - reset of any source leaves on-chip RAM unaltered
// - program counter forced to 0000H while any reset is applied
// - every reset sets stack pointer to 07H
// - after any reset interrupts and timers are disabled
// - watchdog disabled by reset only for power-on reset
// - reset loads every port output register with FFH
// - software reset reloads all shadow bits except the boot select one
// - shadow control bits stay software writable until next reset
// - locked chip returns FFH to programmer flash reads, else true contents
// - config bytes always readable; locked chip refuses config byte erase or program
// - only whole-chip erase clears lock, erasing all flash and config bits
// - lock state does not restrict in-system programming by software
// - data flash enable 1: 16 Kbyte application; 0: split at boundary
// - unprogrammed configuration bytes read all ones
// - writing 1 to software reset trigger resets system; cleared after reset
package bsc_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_PWR_CTL   = 8'h87;
  localparam logic [7:0] IDX_DF_BOUND  = 8'h9c;
  localparam logic [7:0] IDX_CHIP_CTL  = 8'h9f;
  localparam logic [7:0] IDX_PMON_CTL  = 8'ha3;
  localparam logic [7:0] IDX_FOP_TRIG  = 8'ha4;
  localparam logic [7:0] IDX_WDT_B     = 8'hab;
  localparam logic [7:0] IDX_TIMED_ACC = 8'hc7;
  localparam logic [7:0] IDX_WDT_A     = 8'hd8;
  localparam logic [7:0] IDX_CFG_BASE  = 8'hf0;

  // ************************************************************
  // field positions and values
  // ************************************************************
  localparam int unsigned CHIP_SOFTWARE_RESET_TRIGGER_BIT = 7;
  localparam int unsigned CHIP_BS_BIT    = 1;
  localparam int unsigned CFG0_CBS_BIT   = 7;
  localparam int unsigned CFG0_LOCK_BIT  = 1;
  localparam int unsigned CFG0_DATA_FLASH_ENABLE_N_BIT  = 0;
  localparam int unsigned WDT_EN_BIT     = 7;
  localparam int unsigned WDT_RF_BIT     = 3;
  localparam int unsigned PWR_POF_BIT    = 4;
  localparam logic [7:0]  CFG_BLANK      = 8'hff;
  localparam logic [7:0]  PROG_LOCKED_RD = 8'hff;
  localparam logic [7:0]  PORT_RESET_VAL = 8'hff;
  localparam logic [7:0]  SP_RESET_VAL   = 8'h07;
  localparam logic [15:0] PC_RESET_VAL   = 16'h0000;
  localparam logic [15:0] APP_FULL_SIZE  = 16'h4000;
  localparam logic [7:0]  TA_KEY_A       = 8'haa;
  localparam logic [7:0]  TA_KEY_B       = 8'h55;
  localparam logic [7:0]  REG_ZERO       = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ************************************************************
  // timing in machine cycles
  // ************************************************************
  localparam int unsigned CLK_PER_MC_DEF = 1;
  localparam int unsigned TA_WINDOW_MC   = 3;
  localparam int unsigned RST_HOLD_MC    = 2;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_LOAD = 3'b100
  } bsc_rst_state_t;

  typedef enum logic [1:0] {
    PCMD_READ  = 2'b00,
    PCMD_PROG  = 2'b01,
    PCMD_ERASE = 2'b10,
    PCMD_CHIP  = 2'b11
  } bsc_pcmd_t;

  typedef enum logic [1:0] {
    PTGT_APP    = 2'b00,
    PTGT_LOADER = 2'b01,
    PTGT_DATA   = 2'b10,
    PTGT_CONFIG = 2'b11
  } bsc_ptgt_t;

  typedef struct packed {
    bsc_pcmd_t   cmd;
    bsc_ptgt_t   target;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bsc_prog_req_t;

  typedef struct packed {
    logic        hold;
    logic [15:0] pc_val;
    logic        sp_load;
    logic [7:0]  sp_val;
    logic [7:0]  port_val;
    logic        ints_timers_off;
    logic        ram_wr_block;
  } bsc_core_ctl_t;

endpackage : bsc_pkg

// ==== rtl/bsc_loader.sv ====
// module: reset sequencing, configuration loading, boot select and programmer lock
`timescale 1ns/100ps
module bsc_loader
  import bsc_pkg::*;
#(
  parameter int unsigned CLK_PER_MC = CLK_PER_MC_DEF
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic [11:0]   s_awaddr,
  input  wire logic          s_awvalid,
  output logic               s_awready,
  input  wire logic [31:0]   s_wdata,
  input  wire logic [3:0]    s_wstrb,
  input  wire logic          s_wvalid,
  output logic               s_wready,
  output logic [1:0]         s_bresp,
  output logic               s_bvalid,
  input  wire logic          s_bready,
  input  wire logic [11:0]   s_araddr,
  input  wire logic          s_arvalid,
  output logic               s_arready,
  output logic [31:0]        s_rdata,
  output logic [1:0]         s_rresp,
  output logic               s_rvalid,
  input  wire logic          s_rready,
  input  wire logic          ext_rst,
  input  wire logic          wdt_rst,
  input  wire logic          bod_rst,
  input  wire logic          prog_valid,
  input  wire bsc_prog_req_t prog_req,
  input  wire logic [7:0]    flash_rdata,
  output logic               prog_done,
  output logic               prog_refused,
  output logic [7:0]         prog_rdata,
  output logic               flash_prog,
  output logic               flash_erase_all,
  output logic               isp_go,
  output logic               sw_rst_qual,
  output logic               boot_loader,
  output logic               wdt_en,
  output logic [15:0]        app_size,
  output bsc_core_ctl_t      core
);

  localparam int unsigned TA_CYC   = TA_WINDOW_MC * CLK_PER_MC;
  localparam int unsigned HOLD_CYC = RST_HOLD_MC * CLK_PER_MC;

  bsc_rst_state_t st_r;
  logic [7:0]     hold_cnt_r;
  logic           por_r;
  logic           sw_r;
  logic [7:0]     cfg_r [4];
  logic [7:0]     pwr_r, bound_r, pmon_r, fop_r, wdta_r, wdtb_r;
  logic [2:0]     chip_misc_r;
  logic           software_reset_trigger_r, bs_next_r, booted_r, ispen_r;
  logic [1:0]     ta_stage_r;
  logic [7:0]     ta_cnt_r;
  logic           aw_have_r, w_have_r;
  logic [7:0]     wr_idx_r;
  logic           wr_map_r;
  logic [7:0]     wr_data_r;
  logic           wr_lane_r;
  logic           wr_fire;
  logic           wr_prot_ok;
  logic [7:0]     rd_idx;
  logic [7:0]     rd_val;
  logic           rd_map;
  logic           locked;
  logic           src_hw;
  logic           in_rst;

  assign src_hw = ext_rst | wdt_rst | bod_rst;
  assign in_rst = (st_r != ST_RUN);
  assign locked = ~cfg_r[0][CFG0_LOCK_BIT];
  assign sw_rst_qual = sw_r;
  assign boot_loader = booted_r;
  assign wdt_en = wdta_r[WDT_EN_BIT];

  // ************************************************************
  // reset controller
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r       <= ST_HOLD;
      hold_cnt_r <= 8'h00;
      por_r      <= 1'b1;
      sw_r       <= 1'b0;
    end else begin
      case (st_r)
        ST_RUN: begin
          if (src_hw || software_reset_trigger_r) begin
            st_r       <= ST_HOLD;
            hold_cnt_r <= 8'h00;
            por_r      <= 1'b0;
            sw_r       <= ~src_hw;
          end
        end
        ST_HOLD: begin
          if (src_hw) begin
            hold_cnt_r <= 8'h00;
            sw_r       <= 1'b0;
          end else if (hold_cnt_r >= 8'(HOLD_CYC - 1)) begin
            st_r <= ST_LOAD;
          end else begin
            hold_cnt_r <= hold_cnt_r + 8'h01;
          end
        end
        ST_LOAD: st_r <= ST_RUN;
        default: st_r <= ST_HOLD;
      endcase
    end
  end

  // core control, ram write block keeps ram contents across reset
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      core <= '{hold: 1'b1, pc_val: PC_RESET_VAL, sp_load: 1'b1, sp_val: SP_RESET_VAL,
                port_val: PORT_RESET_VAL, ints_timers_off: 1'b1, ram_wr_block: 1'b1};
    end else begin
      core.hold            <= in_rst;
      core.pc_val          <= PC_RESET_VAL;
      core.sp_load         <= in_rst;
      core.sp_val          <= SP_RESET_VAL;
      core.port_val        <= PORT_RESET_VAL;
      core.ints_timers_off <= in_rst;
      core.ram_wr_block    <= in_rst;
    end
  end

  // ************************************************************
  // timed access unlock
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn || in_rst) begin
      ta_stage_r <= 2'd0;
      ta_cnt_r   <= 8'h00;
    end else if (wr_fire && wr_map_r && wr_lane_r && wr_idx_r == IDX_TIMED_ACC) begin
      if (wr_data_r == TA_KEY_A) begin
        ta_stage_r <= 2'd1;
        ta_cnt_r   <= 8'h00;
      end else if (wr_data_r == TA_KEY_B && ta_stage_r == 2'd1) begin
        ta_stage_r <= 2'd2;
      end else begin
        ta_stage_r <= 2'd0;
      end
    end else if (wr_fire) begin
      ta_stage_r <= 2'd0;
    end else if (ta_stage_r == 2'd1) begin
      if (ta_cnt_r >= 8'(TA_CYC - 1)) begin
        ta_stage_r <= 2'd0;
      end else begin
        ta_cnt_r <= ta_cnt_r + 8'h01;
      end
    end
  end

  assign wr_prot_ok = (ta_stage_r == 2'd2);

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  assign s_awready = ~aw_have_r & ~s_bvalid;
  assign s_wready  = ~w_have_r & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign wr_fire   = aw_have_r & w_have_r & ~in_rst;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_idx_r  <= 8'h00;
      wr_map_r  <= 1'b0;
      wr_data_r <= 8'h00;
      wr_lane_r <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_r <= 1'b1;
        wr_idx_r  <= s_awaddr[9:2];
        wr_map_r  <= (s_awaddr[11:10] == 2'b00);
      end
      if (s_wvalid && s_wready) begin
        w_have_r  <= 1'b1;
        wr_data_r <= s_wdata[7:0];
        wr_lane_r <= s_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= (wr_map_r && idx_known(wr_idx_r)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == IDX_PWR_CTL) || (idx == IDX_DF_BOUND) || (idx == IDX_CHIP_CTL) ||
                (idx == IDX_PMON_CTL) || (idx == IDX_FOP_TRIG) || (idx == IDX_WDT_B) ||
                (idx == IDX_TIMED_ACC) || (idx == IDX_WDT_A) || (idx[7:2] == IDX_CFG_BASE[7:2]);
  endfunction : idx_known

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_fire && wr_map_r && wr_lane_r && (wr_idx_r == idx);
  endfunction : wr_hit

  assign rd_idx = s_araddr[9:2];
  assign rd_map = (s_araddr[11:10] == 2'b00) && idx_known(rd_idx);

  always_comb begin
    rd_val = REG_ZERO;
    case (rd_idx)
      IDX_PWR_CTL:   rd_val = pwr_r;
      IDX_DF_BOUND:  rd_val = bound_r;
      IDX_CHIP_CTL:  rd_val = {1'b0, chip_misc_r[2:1], 3'b000, booted_r, ispen_r};
      IDX_PMON_CTL:  rd_val = pmon_r;
      IDX_FOP_TRIG:  rd_val = fop_r;
      IDX_WDT_B:     rd_val = wdtb_r;
      IDX_WDT_A:     rd_val = wdta_r;
      default: begin
        if (rd_idx[7:2] == IDX_CFG_BASE[7:2]) begin
          rd_val = cfg_r[rd_idx[1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= {24'h00_0000, rd_map ? rd_val : REG_ZERO};
      s_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // chip control and boot select
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      software_reset_trigger_r     <= 1'b0;
      bs_next_r   <= 1'b0;
      booted_r    <= 1'b0;
      ispen_r     <= 1'b0;
      chip_misc_r <= 3'b000;
    end else if (in_rst) begin
      if (st_r == ST_HOLD && !sw_r) begin
        bs_next_r <= ~cfg_r[0][CFG0_CBS_BIT];
      end
      if (st_r == ST_LOAD) begin
        software_reset_trigger_r     <= 1'b0;
        booted_r    <= bs_next_r;
        ispen_r     <= 1'b0;
        chip_misc_r <= 3'b000;
      end
    end else if (wr_hit(IDX_CHIP_CTL) && wr_prot_ok) begin
      software_reset_trigger_r     <= wr_data_r[CHIP_SOFTWARE_RESET_TRIGGER_BIT];
      bs_next_r   <= wr_data_r[CHIP_BS_BIT];
      ispen_r     <= wr_data_r[0];
      chip_misc_r <= {wr_data_r[6:5], 1'b0};
    end
  end

  // ************************************************************
  // shadow control bits, power and watchdog registers
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bound_r <= CFG_BLANK;
      pmon_r  <= CFG_BLANK;
    end else if (st_r == ST_LOAD) begin
      bound_r <= cfg_r[1];
      pmon_r  <= {cfg_r[2][7:4], 4'b1000};
    end else if (!in_rst) begin
      if (wr_hit(IDX_DF_BOUND) && wr_prot_ok) begin
        bound_r <= wr_data_r;
      end
      if (wr_hit(IDX_PMON_CTL) && wr_prot_ok) begin
        pmon_r <= wr_data_r;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wdta_r <= REG_ZERO;
      wdtb_r <= REG_ZERO;
      pwr_r  <= REG_ZERO;
    end else if (st_r == ST_LOAD) begin
      if (por_r) begin
        wdta_r <= REG_ZERO;
        pwr_r  <= 8'h10;
      end else begin
        pwr_r <= {2'b00, pwr_r[5:4], 4'h0};
      end
      wdtb_r <= REG_ZERO;
    end else if (in_rst) begin
      if (wdt_rst) begin
        wdta_r[WDT_RF_BIT] <= 1'b1;
      end
    end else begin
      if (wr_hit(IDX_WDT_A) && wr_prot_ok) begin
        wdta_r <= {wr_data_r[7], 1'b0, wdta_r[5], wr_data_r[4:0]};
      end
      if (wr_hit(IDX_WDT_B) && wr_prot_ok) begin
        wdtb_r <= {7'b0000000, wr_data_r[0]};
      end
      if (wr_hit(IDX_PWR_CTL)) begin
        pwr_r <= wr_data_r;
      end
    end
  end

  // ************************************************************
  // software flash operation trigger, independent of lock
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn || in_rst) begin
      fop_r  <= REG_ZERO;
      isp_go <= 1'b0;
    end else begin
      isp_go <= wr_hit(IDX_FOP_TRIG) && wr_prot_ok && wr_data_r[0] && ispen_r;
      fop_r  <= REG_ZERO;
    end
  end

  // ************************************************************
  // partition size
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      app_size <= APP_FULL_SIZE;
    end else if (cfg_r[0][CFG0_DATA_FLASH_ENABLE_N_BIT]) begin
      app_size <= APP_FULL_SIZE;
    end else begin
      app_size <= {bound_r, 8'h00};
    end
  end

  // ************************************************************
  // parallel programmer port and configuration store
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      prog_done       <= 1'b0;
      prog_refused    <= 1'b0;
      prog_rdata      <= PROG_LOCKED_RD;
      flash_prog      <= 1'b0;
      flash_erase_all <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cfg_r[i] <= CFG_BLANK;
      end
    end else begin
      prog_done       <= prog_valid;
      prog_refused    <= 1'b0;
      flash_prog      <= 1'b0;
      flash_erase_all <= 1'b0;
      if (prog_valid) begin
        case (prog_req.cmd)
          PCMD_READ: begin
            if (prog_req.target == PTGT_CONFIG) begin
              prog_rdata <= cfg_r[prog_req.addr[1:0]];
            end else begin
              prog_rdata <= locked ? PROG_LOCKED_RD : flash_rdata;
            end
          end
          PCMD_PROG: begin
            if (prog_req.target != PTGT_CONFIG) begin
              flash_prog <= 1'b1;
            end else if (locked) begin
              prog_refused <= 1'b1;
            end else begin
              cfg_r[prog_req.addr[1:0]] <= cfg_r[prog_req.addr[1:0]] & prog_req.wdata;
            end
          end
          PCMD_ERASE: begin
            if (prog_req.target != PTGT_CONFIG || locked) begin
              prog_refused <= 1'b1;
            end else begin
              cfg_r[prog_req.addr[1:0]] <= CFG_BLANK;
            end
          end
          PCMD_CHIP: begin
            flash_erase_all <= 1'b1;
            for (int i = 0; i < 4; i++) begin
              cfg_r[i] <= CFG_BLANK;
            end
          end
          default: prog_refused <= 1'b1;
        endcase
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_boot_from_bs;
    (st_r == ST_LOAD) |=> (booted_r == $past(bs_next_r));
  endproperty
  a_boot_from_bs: assert property (p_boot_from_bs) else $error("boot block not taken from boot select");

  property p_bs_load;
    (st_r == ST_HOLD && !sw_r) |=> (bs_next_r == ~$past(cfg_r[0][CFG0_CBS_BIT]));
  endproperty
  a_bs_load: assert property (p_bs_load) else $error("boot select not loaded from inverse cbs");

  property p_sw_keeps_bs;
    (st_r == ST_HOLD && sw_r) |=> $stable(bs_next_r);
  endproperty
  a_sw_keeps_bs: assert property (p_sw_keeps_bs) else $error("software reset changed boot select");

  property p_software_reset_trigger_clear;
    (st_r == ST_LOAD) |=> (!software_reset_trigger_r && st_r == ST_RUN);
  endproperty
  a_software_reset_trigger_clear: assert property (p_software_reset_trigger_clear) else $error("software reset bit not cleared");

  property p_pc_hold;
    in_rst |=> (core.hold && core.sp_load && core.pc_val == PC_RESET_VAL && core.sp_val == SP_RESET_VAL);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("core not held at reset vector");

  property p_locked_read;
    (prog_valid && prog_req.cmd == PCMD_READ && prog_req.target != PTGT_CONFIG && locked)
      |=> (prog_rdata == PROG_LOCKED_RD && prog_done);
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read leaked contents");

  property p_locked_cfg;
    (prog_valid && prog_req.cmd == PCMD_PROG && prog_req.target == PTGT_CONFIG && locked)
      |=> (prog_refused && $stable(cfg_r[0]));
  endproperty
  a_locked_cfg: assert property (p_locked_cfg) else $error("locked config programmed");

  property p_chip_erase;
    (prog_valid && prog_req.cmd == PCMD_CHIP) |=> (flash_erase_all && !locked && cfg_r[1] == CFG_BLANK);
  endproperty
  a_chip_erase: assert property (p_chip_erase) else $error("chip erase incomplete");

  property p_partition;
    cfg_r[0][CFG0_DATA_FLASH_ENABLE_N_BIT] |=> (app_size == APP_FULL_SIZE);
  endproperty
  a_partition: assert property (p_partition) else $error("full application size not given");

  c_sw_reset: cover property ((st_r == ST_RUN && software_reset_trigger_r) ##[1:20] (st_r == ST_LOAD && sw_r));
  c_chip_erase: cover property (prog_valid && prog_req.cmd == PCMD_CHIP && locked);
  c_ta_open: cover property (ta_stage_r == 2'd1 ##[1:3] ta_stage_r == 2'd2);

endmodule : bsc_loader

// ==== tb/bsc_flash_model.sv ====
// flash array model answering programmer reads
`timescale 1ns/100ps
module bsc_flash_model
  import bsc_pkg::*;
#(
  parameter logic [7:0] PATTERN = 8'h5a
) (
  input  wire logic          ref_clk,
  input  wire logic          prog_valid,
  input  wire bsc_prog_req_t prog_req,
  output logic [7:0]         flash_rdata
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge ref_clk) begin
    if (prog_valid) last_r <= flash_rdata;
  end
  // released between requests: inverse of last byte
  always_comb begin
    flash_rdata = prog_valid ? (prog_req.addr[7:0] ^ PATTERN) : ~last_r;
  end
endmodule : bsc_flash_model

// ==== tb/boot_select_config_load_tb.sv ====
// testbench for the boot select and configuration loader
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module boot_select_config_load_tb
  import bsc_pkg::*;
;
  logic ref_clk, rstn, ext_rst, wdt_rst, bod_rst, prog_valid;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic prog_done, prog_refused, flash_prog, flash_erase_all, isp_go, sw_rst_qual, boot_loader, wdt_en;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [7:0] flash_rdata, prog_rdata, a8;
  logic [15:0] app_size;
  bsc_prog_req_t prog_req;
  bsc_core_ctl_t core;
  int err_total, samples_checked, n;
  // ************************************************************
  // design and far side
  // ************************************************************
  bsc_loader #(.CLK_PER_MC(2)) dut_u (.ref_clk, .rstn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .ext_rst, .wdt_rst, .bod_rst, .prog_valid, .prog_req,
    .flash_rdata, .prog_done, .prog_refused, .prog_rdata, .flash_prog, .flash_erase_all, .isp_go,
    .sw_rst_qual, .boot_loader, .wdt_en, .app_size, .core);
  bsc_flash_model fm_u (.ref_clk, .prog_valid, .prog_req, .flash_rdata);
  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [7:0] exp_rd(input logic unl, input logic [7:0] a);
    return unl ? (a ^ 8'h5a) : PROG_LOCKED_RD;
  endfunction : exp_rd
  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic tmo();
    err_total++;
    end_of_test();
  endtask : tmo
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= {24'h00_0000, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) break;
    end
    s_bready <= 1'b0;
    if (n == 40) tmo();
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) break;
    end
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
    if (n == 40) tmo();
  endtask : rdr
  task automatic wh(input logic v);
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (core.hold === v) break;
    end
    if (n == 60) tmo();
  endtask : wh
  task automatic pg(input bsc_pcmd_t c, input bsc_ptgt_t t, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    prog_valid <= 1'b1;
    prog_req <= '{c, t, {8'h00, a}, d};
    @(posedge ref_clk);
    prog_valid <= 1'b0;
    #1;
  endtask : pg
  task automatic ta_open();
    wr(12'h31c, TA_KEY_A);
    wr(12'h31c, TA_KEY_B);
  endtask : ta_open
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    {rstn, ext_rst, wdt_rst, bod_rst, prog_valid, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata, err_total, samples_checked} = '0;
    s_wstrb = 4'h1;
    prog_req = '0;
    n = $urandom(69);
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(core.hold, 1'b1)
    `CHK(core.pc_val, PC_RESET_VAL)
    `CHK(core.sp_val, SP_RESET_VAL)
    `CHK(core.port_val, PORT_RESET_VAL)
    `CHK({core.ints_timers_off, core.ram_wr_block}, 2'b11)
    rstn <= 1'b1;
    wh(1'b0);
    repeat (2) @(posedge ref_clk);
    `CHK({wdt_en, boot_loader, app_size}, {2'b00, APP_FULL_SIZE})
    rdr(12'h3c0);
    `CHK(rd, 32'h0000_00ff)
    rdr(12'h004);
    `CHK(rr, RESP_SLVERR)
    repeat (6) begin
      a8 = $urandom;
      pg(PCMD_READ, bsc_ptgt_t'(a8[1:0] % 3), a8, 8'h00);
      `CHK({prog_done, prog_rdata}, {1'b1, exp_rd(1'b1, a8)})
    end
    pg(PCMD_PROG, PTGT_CONFIG, 8'h00, 8'h7d);
    `CHK(prog_refused, 1'b0)
    pg(PCMD_READ, PTGT_APP, 8'h12, 8'h00);
    `CHK(prog_rdata, exp_rd(1'b0, 8'h12))
    pg(PCMD_PROG, PTGT_CONFIG, 8'h00, 8'h7d);
    `CHK(prog_refused, 1'b1)
    pg(PCMD_ERASE, PTGT_CONFIG, 8'h01, 8'h00);
    `CHK(prog_refused, 1'b1)
    pg(PCMD_PROG, PTGT_DATA, 8'h40, 8'h3c);
    `CHK({flash_prog, prog_refused}, 2'b10)
    rdr(12'h3c0);
    `CHK(rd, 32'h0000_007d)
    ta_open();
    wr(12'h360, 8'h80);
    {bod_rst, wdt_rst, ext_rst} <= 3'b001 << ($urandom % 3);
    wh(1'b1);
    `CHK({core.sp_load, core.ints_timers_off, core.ram_wr_block, core.pc_val}, {3'b111, PC_RESET_VAL})
    {bod_rst, wdt_rst, ext_rst} <= 3'b000;
    wh(1'b0);
    `CHK({boot_loader, wdt_en, core.sp_load, core.ints_timers_off, core.ram_wr_block}, 5'b11000)
    rdr(12'h27c);
    `CHK(rd[1], 1'b1)
    ta_open();
    wr(12'h27c, 8'h80);
    wh(1'b1);
    `CHK(sw_rst_qual, 1'b1)
    wh(1'b0);
    repeat (2) @(posedge ref_clk);
    `CHK(boot_loader, 1'b0)
    rdr(12'h27c);
    `CHK(rd[7:0] & 8'h82, REG_ZERO)
    rdr(12'h270);
    `CHK(rd, 32'h0000_00ff)
    a8 = $urandom;
    ta_open();
    wr(12'h270, a8);
    rdr(12'h270);
    `CHK(rd, {24'h00_0000, a8})
    ta_open();
    wr(12'h27c, 8'h01);
    ta_open();
    wr(12'h290, 8'h01);
    `CHK(isp_go, 1'b1)
    pg(PCMD_CHIP, PTGT_APP, 8'h00, 8'h00);
    `CHK(flash_erase_all, 1'b1)
    rdr(12'h3c0);
    `CHK(rd[7:0], CFG_BLANK)
    pg(PCMD_READ, PTGT_LOADER, 8'h33, 8'h00);
    `CHK(prog_rdata, exp_rd(1'b1, 8'h33))
    pg(PCMD_PROG, PTGT_CONFIG, 8'h00, 8'hfe);
    @(posedge ref_clk);
    #1;
    `CHK(app_size, {a8, 8'h00})
    end_of_test();
  end
endmodule : boot_select_config_load_tb
